// ### design/fllcs_ffclk_init.sv
// Fixed-frequency clock, enable flag and start-up sequencing
`timescale 1ns/1ps
module fllcs_ffclk_init
    import fllcs_pkg::*;
#(
    parameter int STARTUP_CYC = REF_STARTUP_CYC,
    parameter int ACQ_CYC = ACQUIRE_CYC,
    parameter int OSC_CYC = OSC_INIT_CYC
) (
    input wire logic i_core_clk,            // Core clock
    input wire logic i_srst,                // Synchronous reset
    input wire logic i_ref_clk,             // Undivided reference clock level
    input wire logic i_mode_wr,             // First control register write
    input wire logic [1:0] i_mode,          // Requested clock mode
    input wire logic [1:0] i_bus_div,       // Requested bus divider code
    input wire logic [2:0] i_ref_div,       // Requested reference divider
    input wire logic i_ctl2_wr,             // Second control register write
    input wire logic i_ext_ref_sel,         // External reference select
    input wire logic i_low_power,           // Bypass low power bit
    input wire logic i_trim_wr,             // Trim register write
    input wire logic [7:0] i_coarse_trim,   // Coarse trim value
    input wire logic i_fine_trim,           // Fine trim bit
    output logic o_fixed_freq_clock,        // Divided reference clock
    output logic o_fixed_freq_enable,       // Fixed clock qualifier
    output logic [1:0] o_mode,              // Current clock mode
    output logic [1:0] o_bus_div,           // Current bus divider
    output logic [2:0] o_ref_div,           // Current reference divider
    output logic o_ext_ref_sel,             // External reference selected
    output logic o_low_power,               // Low power bit
    output logic o_osc_init_done,           // Oscillator initialised
    output logic o_ref_stable,              // Internal reference stable
    output logic o_fll_locked,              // FLL lock reached
    output logic [7:0] o_coarse_trim,       // Coarse trim register
    output logic o_fine_trim                // Fine trim bit
);
    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    fllcs_mode_e mode;
    logic [31:0] st_cnt;
    logic [31:0] acq_cnt;
    logic [31:0] osc_cnt;
    logic [7:0] div_cnt;
    logic ref_q;
    logic ffclk;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mode <= FLLCS_ENG_INT;
            o_bus_div <= BUS_DIV_RESET;
            o_ref_div <= REF_DIV_RESET;
        end else if (i_mode_wr) begin
            mode <= fllcs_mode_e'(i_mode);
            o_bus_div <= i_bus_div;
            o_ref_div <= i_ref_div;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ext_ref_sel <= 1'b0;
            o_low_power <= 1'b0;
        end else if (i_ctl2_wr) begin
            o_ext_ref_sel <= i_ext_ref_sel;
            o_low_power <= i_low_power;
        end
    end

    // Trim holds its reset value until software copies it in; no autoload
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_coarse_trim <= COARSE_TRIM_RESET;
            o_fine_trim <= FINE_TRIM_RESET;
        end else if (i_trim_wr) begin
            o_coarse_trim <= i_coarse_trim;
            o_fine_trim <= i_fine_trim;
        end
    end

    // ------------------------------------------------------------------
    // Reference start-up, lock and oscillator init
    // ------------------------------------------------------------------
    wire st_done = (st_cnt >= 32'(STARTUP_CYC));
    wire acq_done = (acq_cnt >= 32'(ACQ_CYC));
    wire osc_done = (osc_cnt >= 32'(OSC_CYC));

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st_cnt <= 32'h0;
            acq_cnt <= 32'h0;
        end else begin
            if (!st_done)
                st_cnt <= st_cnt + 32'h1;
            if (st_done && !acq_done)
                acq_cnt <= acq_cnt + 32'h1;
        end
    end

    // Deselecting the external reference restarts the oscillator count
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !o_ext_ref_sel)
            osc_cnt <= 32'h0;
        else if (!osc_done)
            osc_cnt <= osc_cnt + 32'h1;
    end

    assign o_ref_stable = st_done;
    assign o_fll_locked = st_done && acq_done;
    assign o_osc_init_done = o_ext_ref_sel && osc_done;
    assign o_mode = mode;

    // ------------------------------------------------------------------
    // Fixed-frequency clock: reference divided by 2^(ref_div+1)
    // ------------------------------------------------------------------
    wire ref_rise = i_ref_clk && !ref_q;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ref_q <= 1'b0;
            div_cnt <= 8'h0;
            ffclk <= 1'b0;
        end else begin
            ref_q <= i_ref_clk;
            if (ref_rise)
                div_cnt <= div_cnt + 8'h1;
            ffclk <= div_cnt[o_ref_div];
        end
    end

    assign o_fixed_freq_clock = ffclk;

    // ------------------------------------------------------------------
    // Enable flag
    // ------------------------------------------------------------------
    // Threshold is bus code plus two, which keeps the output clock at four
    // or more times the fixed clock in every bypass setting
    function automatic logic ffe_bypass_ok(
        input logic [1:0] bus_div,
        input logic [2:0] ref_div
    );
        logic [2:0] ref_div_min;
        ref_div_min = {1'b0, bus_div} + ENABLE_DIV_OFFSET;
        return ref_div >= ref_div_min;
    endfunction : ffe_bypass_ok

    wire engaged = (mode == FLLCS_ENG_INT) || (mode == FLLCS_ENG_EXT);
    wire byp_ok = ffe_bypass_ok(o_bus_div, o_ref_div);

    assign o_fixed_freq_enable = engaged || byp_ok;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_engaged_ffe;
        @(posedge i_core_clk) disable iff (i_srst)
        engaged |-> o_fixed_freq_enable;
    endproperty
    a_engaged_ffe: assert property (p_engaged_ffe)
        else $error("enable low in engaged mode");

    property p_bypass_ffe;
        @(posedge i_core_clk) disable iff (i_srst)
        !engaged |-> (o_fixed_freq_enable ==
            (o_ref_div >= 3'({1'b0, o_bus_div} + 3'h2)));
    endproperty
    a_bypass_ffe: assert property (p_bypass_ffe)
        else $error("bypass enable table wrong");

    property p_ffe_ratio;
        @(posedge i_core_clk) disable iff (i_srst)
        (!engaged && o_fixed_freq_enable) |->
            (o_ref_div > {1'b0, o_bus_div} + 3'h1);
    endproperty
    a_ffe_ratio: assert property (p_ffe_ratio)
        else $error("enable set below four times ratio");

    property p_reset_state;
        @(posedge i_core_clk)
        i_srst |=> (mode == FLLCS_ENG_INT && o_bus_div == 2'h1);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset mode or divider wrong");

    property p_lock_order;
        @(posedge i_core_clk) disable iff (i_srst)
        o_fll_locked |-> o_ref_stable;
    endproperty
    a_lock_order: assert property (p_lock_order)
        else $error("lock before reference stable");

    property p_trim_hold;
        @(posedge i_core_clk) disable iff (i_srst)
        !i_trim_wr |=> $stable(o_coarse_trim) && $stable(o_fine_trim);
    endproperty
    a_trim_hold: assert property (p_trim_hold)
        else $error("trim changed without write");

    property p_osc_init;
        @(posedge i_core_clk) disable iff (i_srst)
        o_osc_init_done |-> o_ext_ref_sel;
    endproperty
    a_osc_init: assert property (p_osc_init)
        else $error("oscillator done without select");

    property p_ffclk_follow;
        @(posedge i_core_clk) disable iff (i_srst)
        ##1 (o_fixed_freq_clock == $past(div_cnt[o_ref_div]));
    endproperty
    a_ffclk_follow: assert property (p_ffclk_follow)
        else $error("fixed clock not from divider");

    property p_mode_load;
        @(posedge i_core_clk) disable iff (i_srst)
        i_mode_wr |=> (o_mode == $past(i_mode)) &&
            (o_bus_div == $past(i_bus_div)) &&
            (o_ref_div == $past(i_ref_div));
    endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("mode write not taken");

    property p_osc_restart;
        @(posedge i_core_clk) disable iff (i_srst)
        !o_ext_ref_sel |=> !o_osc_init_done;
    endproperty
    a_osc_restart: assert property (p_osc_restart)
        else $error("oscillator done without init cycles");

    property p_acq_after_stable;
        @(posedge i_core_clk) disable iff (i_srst)
        $rose(o_ref_stable) |-> !o_fll_locked;
    endproperty
    a_acq_after_stable: assert property (p_acq_after_stable)
        else $error("lock without acquire time");
endmodule : fllcs_ffclk_init

// ### design/fllcs_pkg.sv
// Constants for the fixed-frequency clock and start-up logic of the clock unit
// ----------------------------------------------------------------------------
// Behaviour
// - The divided reference clock leaves as the fixed-frequency clock.
// - Enable high only if output is four or more times the fixed clock.
// - In both engaged modes the fixed-frequency enable is always high.
// - Bypass enable: bus 00/ref>=010, 01/>=011, 10/>=100, 11/>=101.
// - After reset: engaged-internal mode, bus divider at divide by 2.
// - Lock follows within acquire time, once the reference is stable.
// - Hardware never loads trim; software writes it after power-on.
// - With external select set, oscillator-done rises after init cycles.
// ----------------------------------------------------------------------------
package fllcs_pkg;
    typedef enum logic [1:0] {
        FLLCS_ENG_INT,
        FLLCS_ENG_EXT,
        FLLCS_BYP_INT,
        FLLCS_BYP_EXT
    } fllcs_mode_e;

    localparam logic [1:0] BUS_DIV_RESET = 2'h1;
    localparam logic [7:0] COARSE_TRIM_RESET = 8'h80;
    localparam logic FINE_TRIM_RESET = 1'b0;
    localparam logic [2:0] REF_DIV_RESET = 3'h0;
    // Enable threshold: reference divider must be at least bus code + 2
    localparam logic [2:0] ENABLE_DIV_OFFSET = 3'h2;
    localparam int CLK_MHZ = 40;
    localparam int REF_STARTUP_US = 60;
    localparam int REF_STARTUP_CYC = REF_STARTUP_US * CLK_MHZ;
    localparam int ACQUIRE_MS = 1;
    localparam int ACQUIRE_CYC = ACQUIRE_MS * 1000 * CLK_MHZ;
    localparam int OSC_INIT_CYC = 4096;
endpackage : fllcs_pkg

// ### sim/fllcs_ref_model.sv
// Free-running reference oscillator model
`timescale 1ns/1ps
module fllcs_ref_model #(
    parameter int HALF = 2
) (
    input wire logic i_core_clk, // Core clock
    output logic o_ref_clk       // Reference level
);
    int cnt;
    initial begin
        o_ref_clk = 1'b0;
        cnt = 0;
    end
    // Runs free: the internal reference never pauses
    always @(negedge i_core_clk) begin
        cnt = (cnt + 1) % HALF;
        if (cnt == 0) o_ref_clk = ~o_ref_clk;
    end
endmodule : fllcs_ref_model

// ### sim/tb_top.sv
// Self-checking bench for the fixed clock and start-up logic
`timescale 1ns/1ps
module tb_top;
    import fllcs_pkg::*;
    logic clk = 0, srst = 1, rclk, mwr = 0, c2wr = 0, twr = 0;
    logic [1:0] m = 0, b = 0, om, ob;
    logic [2:0] r = 0, orr;
    logic ers = 0, lpb = 0, ft = 0, ffc, ffe, oers, olp, oid, stb, lck, oft;
    logic [7:0] ct = 0, oct;
    // Stored trim image: fine bit 0 at 0xffae, coarse byte at 0xffaf
    logic [7:0] nvm_fine = 8'h01, nvm_coarse = 8'h5a;
    int mismatches = 0, check_count = 0, n0, n1;
    always #12.5 clk = ~clk;
    fllcs_ref_model i_ref (.i_core_clk(clk), .o_ref_clk(rclk));
    fllcs_ffclk_init #(.STARTUP_CYC(10), .ACQ_CYC(20), .OSC_CYC(8)) i_dut (
        .i_core_clk(clk), .i_srst(srst), .i_ref_clk(rclk),
        .i_mode_wr(mwr), .i_mode(m), .i_bus_div(b), .i_ref_div(r),
        .i_ctl2_wr(c2wr), .i_ext_ref_sel(ers), .i_low_power(lpb),
        .i_trim_wr(twr), .i_coarse_trim(ct), .i_fine_trim(ft),
        .o_fixed_freq_clock(ffc), .o_fixed_freq_enable(ffe),
        .o_mode(om), .o_bus_div(ob), .o_ref_div(orr),
        .o_ext_ref_sel(oers), .o_low_power(olp), .o_osc_init_done(oid),
        .o_ref_stable(stb), .o_fll_locked(lck),
        .o_coarse_trim(oct), .o_fine_trim(oft));
    task automatic chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic mwrite(input logic [1:0] mm, bb, input logic [2:0] rr);
        @(negedge clk);
        {mwr, m, b, r} = {1'b1, mm, bb, rr};
        @(negedge clk);
        mwr = 0;
    endtask : mwrite
    task automatic c2write(input logic e, l);
        @(negedge clk);
        {c2wr, ers, lpb} = {1'b1, e, l};
        @(negedge clk);
        c2wr = 0;
    endtask : c2write
    // Code is mode[6:5], bus divider[4:3], reference divider[2:0]
    function automatic logic ffe_exp(input logic [6:0] code);
        logic [2:0] lim;
        case (code[4:3])
            2'h0: lim = 3'h2;
            2'h1: lim = 3'h3;
            2'h2: lim = 3'h4;
            default: lim = 3'h5;
        endcase
        return !code[6] || code[2:0] >= lim;
    endfunction : ffe_exp
    task automatic count_ffc(output int n);
        logic last;
        n = 0;
        last = ffc;
        repeat (128) begin
            @(negedge clk);
            if (ffc !== last) n++;
            last = ffc;
        end
    endtask : count_ffc
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        #50000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge clk);
        srst = 0;
        chk("mode", om, 8'h0);
        chk("bus_div", ob, 8'h1);
        chk("ref_div", orr, 8'h0);
        chk("ffe", ffe, 8'h1);
        chk("coarse", oct, 8'h80);
        chk("fine", oft, 8'h0);
        repeat (4) @(negedge clk);
        chk("stable", stb, 8'h0);
        repeat (10) @(negedge clk);
        chk("stable", stb, 8'h1);
        chk("locked", lck, 8'h0);
        repeat (22) @(negedge clk);
        chk("locked", lck, 8'h1);
        $display("test startup done");
        // Software copies the stored trim image; hardware never does
        {twr, ct, ft} = {1'b1, nvm_coarse, nvm_fine[0]};
        @(negedge clk);
        twr = 0;
        chk("coarse", oct, 8'h5a);
        chk("fine", oft, 8'h1);
        $display("test trim done");
        // External source settled before any external mode is chosen
        c2write(1'b1, 1'b0);
        repeat (12) @(negedge clk);
        chk("osc_done", oid, 8'h1);
        // Divide by 1 only appears after trimming
        for (int i = 0; i < 128; i++) begin
            c2write(1'b1, i[6:5] == 2'h3);
            mwrite(i[6:5], i[4:3], i[2:0]);
            chk("mode", om, i[6:5]);
            chk("bus_div", ob, i[4:3]);
            chk("ref_div", orr, i[2:0]);
            chk("ffe", ffe, ffe_exp(i[6:0]));
        end
        $display("test enable table done");
        mwrite(2'h0, 2'h1, 3'h0);
        count_ffc(n0);
        mwrite(2'h0, 2'h1, 3'h1);
        count_ffc(n1);
        chk("ffclk_div2", n0 >= 30 && n0 <= 34, 8'h1);
        chk("ffclk_div4", n1 >= 14 && n1 <= 18, 8'h1);
        $display("test fixed clock done");
        // Drop the external source, then switch to it afresh
        c2write(1'b0, 1'b0);
        chk("osc_done", oid, 8'h0);
        c2write(1'b1, 1'b1);
        chk("ext_sel", oers, 8'h1);
        chk("low_power", olp, 8'h1);
        chk("osc_done", oid, 8'h0);
        repeat (12) @(negedge clk);
        chk("osc_done", oid, 8'h1);
        mwrite(2'h3, 2'h1, 3'h3);
        chk("mode", om, 8'h3);
        chk("ffe", ffe, 8'h1);
        mwrite(2'h2, 2'h1, 3'h2);
        chk("mode", om, 8'h2);
        chk("ffe", ffe, 8'h0);
        c2write(1'b0, 1'b0);
        chk("osc_done", oid, 8'h0);
        $display("test mode switch done");
        // A reset in mid-run brings back the start-up state
        @(negedge clk);
        srst = 1;
        repeat (2) @(negedge clk);
        srst = 0;
        chk("mode", om, 8'h0);
        chk("bus_div", ob, 8'h1);
        chk("ref_div", orr, 8'h0);
        chk("ffe", ffe, 8'h1);
        chk("coarse", oct, 8'h80);
        chk("fine", oft, 8'h0);
        chk("ext_sel", oers, 8'h0);
        chk("stable", stb, 8'h0);
        $display("test mid-run reset done");
        summarize();
    end
endmodule : tb_top
